// >>> inc/spl_params.svh
`ifndef SPL_PARAMS_SVH
`define SPL_PARAMS_SVH

// Clock and timing.
`define SPL_CLK_HZ          100000000
`define SPL_CLK_PERIOD_NS   10
`define SPL_ONLINE_DELAY_MS 1000
`define SPL_OVERSAMPLE      16
`define SPL_TICK_LAST       4'hF
`define SPL_TICK_MID        4'h7

// Baud rates selected by codes 1 to D.
`define SPL_BAUD_1 110
`define SPL_BAUD_2 300
`define SPL_BAUD_3 600
`define SPL_BAUD_4 1200
`define SPL_BAUD_5 2400
`define SPL_BAUD_6 4800
`define SPL_BAUD_7 9600
`define SPL_BAUD_8 19200
`define SPL_BAUD_9 28800
`define SPL_BAUD_A 38400
`define SPL_BAUD_B 57600
`define SPL_BAUD_C 115200
`define SPL_BAUD_D 230400
`define SPL_DIV(b) ((`SPL_CLK_HZ / (`SPL_OVERSAMPLE * (b))) - 1)

// Code limits and flow characters.
`define SPL_FMT_MAX   4'h7
`define SPL_BAUD_MAX  4'hD
`define SPL_XON       8'h11
`define SPL_XOFF      8'h13

// Register byte offsets.
`define SPL_REG_SETTINGS 5'h00
`define SPL_REG_CMD      5'h04
`define SPL_REG_STATUS   5'h08
`define SPL_REG_TXDATA   5'h0C
`define SPL_REG_RXDATA   5'h10
`define SPL_REG_COUNT    5'h14
`define SPL_REG_IRQ_STAT 5'h18
`define SPL_REG_IRQ_MASK 5'h1C

// Command register bits.
`define SPL_CMD_LOAD   0
`define SPL_CMD_STORE  1
`define SPL_CMD_ABORT  2
`define SPL_CMD_FINISH 3

// Interrupt status bits.
`define SPL_IRQ_W       7
`define SPL_IRQ_RX      0
`define SPL_IRQ_TXE     1
`define SPL_IRQ_PAR     2
`define SPL_IRQ_FRM     3
`define SPL_IRQ_ONLINE  4
`define SPL_IRQ_ABORT   5
`define SPL_IRQ_OVR     6

`endif

// >>> inc/spl_pkg.sv
package spl_pkg;

  // Transfer sequencer states, Gray coded in the order listed.
  typedef enum logic [2:0] {
    SPL_IDLE    = 3'h0,
    SPL_SETUP   = 3'h1,
    SPL_WAIT    = 3'h3,
    SPL_DELAY   = 3'h2,
    SPL_XFER    = 3'h6,
    SPL_PAUSED  = 3'h7,
    SPL_DONE    = 3'h5,
    SPL_ABORTED = 3'h4
  } spl_state_t;

  // Flow protocol codes; 4 and 5 are unused.
  typedef enum logic [3:0] {
    SPL_PROT_UNSET  = 4'h0,
    SPL_PROT_RTSCTS = 4'h1,
    SPL_PROT_XONOFF = 4'h2,
    SPL_PROT_LEGACY = 4'h3,
    SPL_PROT_REMOTE = 4'h6
  } spl_prot_t;

  // The four link settings, packed as the settings register holds them.
  typedef struct packed {
    logic [3:0] prog_type;
    logic [3:0] flow_protocol_select;
    logic [3:0] baud_code;
    logic [3:0] char_format;
  } spl_settings_t;

  // Frame layout decoded from the character format code.
  typedef struct packed {
    logic par_en;
    logic par_odd;
    logic eight;
    logic rs244;
  } spl_frame_t;

endpackage

// >>> src/spl_baud.sv
`timescale 1ns/10ps
`default_nettype none
`include "spl_params.svh"

module spl_baud
  import spl_pkg::*;
(
  // Clock and synchronised reset.
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  // Baud code from the settings.
  input  wire logic [3:0] baud_code_i,
  // Sixteen-times bit rate enable.
  output logic            tick_o
);

  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        next_tick;
  logic [15:0] div;

  // Divisor per baud code; unknown codes give no ticks at all.
  always_comb begin
    case (baud_code_i)
      4'h1:    div = 16'(`SPL_DIV(`SPL_BAUD_1));
      4'h2:    div = 16'(`SPL_DIV(`SPL_BAUD_2));
      4'h3:    div = 16'(`SPL_DIV(`SPL_BAUD_3));
      4'h4:    div = 16'(`SPL_DIV(`SPL_BAUD_4));
      4'h5:    div = 16'(`SPL_DIV(`SPL_BAUD_5));
      4'h6:    div = 16'(`SPL_DIV(`SPL_BAUD_6));
      4'h7:    div = 16'(`SPL_DIV(`SPL_BAUD_7));
      4'h8:    div = 16'(`SPL_DIV(`SPL_BAUD_8));
      4'h9:    div = 16'(`SPL_DIV(`SPL_BAUD_9));
      4'hA:    div = 16'(`SPL_DIV(`SPL_BAUD_A));
      4'hB:    div = 16'(`SPL_DIV(`SPL_BAUD_B));
      4'hC:    div = 16'(`SPL_DIV(`SPL_BAUD_C));
      4'hD:    div = 16'(`SPL_DIV(`SPL_BAUD_D));
      default: div = 16'hFFFF;
    endcase
  end

  // Free-running divider; a code change restarts the count at the next wrap.
  always_comb begin
    next_tick = 1'b0;
    next_cnt  = cnt + 16'h0001;
    if (baud_code_i == 4'h0 || baud_code_i > `SPL_BAUD_MAX) begin
      next_cnt = 16'h0000;
    end else if (cnt >= div) begin
      next_cnt  = 16'h0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= 16'h0000;
      tick_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      tick_o <= next_tick;
    end
  end

endmodule // spl_baud
`default_nettype wire

// >>> src/spl_uart.sv
// Summary of operation
// - Six framings: none, even or odd parity with seven or eight data bits.
// - Format seven uses punched-tape odd-parity coding instead of plain framing.
// - Transmitter always sends two stop bits; receiver accepts one or two.
// - Baud codes 1 to 7 select 110 to 9600 baud.
// - Baud codes 8 to D select 19.2K to 230K baud.
// - Protocol codes: 1 hardware, 2 XON/XOFF, 3 legacy, 6 remote station.
// - One set of settings governs both receive and transmit directions.
// - Zero settings are unset and must be supplied before the transfer starts.
// - Start asserts the status output once the settings are valid, then waits until the remote is online.
// - After the remote comes online, wait one second before any character.
// - Remote status line dropping suspends the transfer until it returns.
// - Abort ends the transfer with aborted status; a second abort goes idle.
// - Running byte count is visible; a finished load reports loaded status.
// - Status output goes to the remote; remote status input is sampled.
`timescale 1ns/10ps
`default_nettype none
`include "spl_params.svh"

module spl_uart
  import spl_pkg::*;
#(
  parameter int unsigned ONLINE_DELAY_CYC = `SPL_ONLINE_DELAY_MS * (1000000 / `SPL_CLK_PERIOD_NS)
) (
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Avalon-MM register slave.
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Interrupt.
  output logic             irq_o,
  // Serial link pins.
  input  wire logic        rxd_i,
  output logic             txd_o,
  input  wire logic        stat_in_i,
  output logic             ctrl_out_o
);

  // Reset release through two flops; everything else uses rst_n.
  logic [1:0] rst_q;
  logic       rst_n;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rst_q <= 2'b00;
    else rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // Pin inputs pass three flops; a level counts once the last two agree.
  logic [2:0] rx_sync, st_sync;
  logic       rx_line, online;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync <= 3'b111;
      st_sync <= 3'b000;
      rx_line <= 1'b1;
      online  <= 1'b0;
    end else begin
      rx_sync <= {rx_sync[1:0], rxd_i};
      st_sync <= {st_sync[1:0], stat_in_i};
      if (rx_sync[1] == rx_sync[2]) rx_line <= rx_sync[2];
      if (st_sync[1] == st_sync[2]) online <= st_sync[2];
    end
  end

  // Register state.
  spl_settings_t           settings, next_settings;
  logic [`SPL_IRQ_W-1:0]   irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic [31:0]             count, next_count, next_rdata;
  logic [7:0]              tx_hold, next_tx_hold, rx_data, next_rx_data;
  logic                    tx_full, next_tx_full, rx_valid, next_rx_valid;
  logic                    xoff, next_xoff, next_wait, next_irq;
  spl_state_t              state, next_state;
  logic                    mode_store, next_mode_store, next_ctrl_out;
  logic [31:0]             dly_cnt, next_dly_cnt;
  spl_frame_t              fr;
  logic                    tick;

  // Bus decode: one wait cycle, then the access completes.
  logic wr, rd_take, cmd_load, cmd_store, cmd_abort, cmd_finish, settings_ok, active;
  assign wr         = avs_write_i & ~avs_waitrequest_o;
  assign rd_take    = avs_read_i & ~avs_waitrequest_o;
  assign cmd_load   = wr && avs_address_i == `SPL_REG_CMD && avs_writedata_i[`SPL_CMD_LOAD];
  assign cmd_store  = wr && avs_address_i == `SPL_REG_CMD && avs_writedata_i[`SPL_CMD_STORE];
  assign cmd_abort  = wr && avs_address_i == `SPL_REG_CMD && avs_writedata_i[`SPL_CMD_ABORT];
  assign cmd_finish = wr && avs_address_i == `SPL_REG_CMD && avs_writedata_i[`SPL_CMD_FINISH];
  assign active     = (state == SPL_XFER);

  // Every setting must be nonzero, and format, baud and protocol a known code, before the link starts.
  assign settings_ok = settings.char_format != 4'h0 && settings.char_format <= `SPL_FMT_MAX
                    && settings.baud_code != 4'h0 && settings.baud_code <= `SPL_BAUD_MAX
                    && settings.prog_type != 4'h0
                    && (settings.flow_protocol_select == SPL_PROT_RTSCTS
                     || settings.flow_protocol_select == SPL_PROT_XONOFF
                     || settings.flow_protocol_select == SPL_PROT_LEGACY
                     || settings.flow_protocol_select == SPL_PROT_REMOTE);

  // Framing decode, shared by both directions so they can never disagree.
  always_comb begin
    fr = '0;
    case (settings.char_format)
      4'h2:    fr = '{par_en: 1'b0, par_odd: 1'b0, eight: 1'b1, rs244: 1'b0};
      4'h3:    fr = '{par_en: 1'b1, par_odd: 1'b0, eight: 1'b0, rs244: 1'b0};
      4'h4:    fr = '{par_en: 1'b1, par_odd: 1'b0, eight: 1'b1, rs244: 1'b0};
      4'h5:    fr = '{par_en: 1'b1, par_odd: 1'b1, eight: 1'b0, rs244: 1'b0};
      4'h6:    fr = '{par_en: 1'b1, par_odd: 1'b1, eight: 1'b1, rs244: 1'b0};
      4'h7:    fr = '{par_en: 1'b0, par_odd: 1'b1, eight: 1'b1, rs244: 1'b1};
      default: fr = '0;
    endcase
  end

  spl_baud u_baud (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n),
    .baud_code_i (settings.baud_code),
    .tick_o      (tick)
  );

  // Transmitter: ten- to twelve-bit frame shifted out LSB first, sixteen ticks a bit.
  logic [11:0] tx_sh, next_tx_sh;
  logic [3:0]  tx_left, next_tx_left, tx_tk, next_tx_tk;
  logic        tx_busy, next_tx_busy, tx_start, tx_done, next_txd;
  logic [7:0]  tx_d;
  logic        tx_pb;
  assign tx_start = active && tx_full && !tx_busy && !xoff;
  assign tx_done  = tx_busy && tick && tx_tk == `SPL_TICK_LAST && tx_left == 4'h1;

  always_comb begin
    next_tx_sh   = tx_sh;
    next_tx_left = tx_left;
    next_tx_tk   = tx_tk;
    next_tx_busy = tx_busy;
    tx_d         = fr.eight ? tx_hold : {1'b0, tx_hold[6:0]};
    if (fr.rs244) tx_d = {tx_hold[6:4], ~^tx_hold[6:0], tx_hold[3:0]};
    tx_pb = fr.par_odd ? ~^tx_d : ^tx_d;
    if (tx_start) begin
      next_tx_sh      = 12'hFFE; // Start bit low, all trailing bits high for stops.
      next_tx_sh[8:1] = fr.eight ? tx_d : {1'b1, tx_d[6:0]};
      if (fr.par_en && fr.eight) next_tx_sh[9] = tx_pb;
      if (fr.par_en && !fr.eight) next_tx_sh[8] = tx_pb;
      next_tx_left = 4'h3 + (fr.eight ? 4'h8 : 4'h7) + {3'h0, fr.par_en}; // Two stop bits.
      next_tx_tk   = 4'h0;
      next_tx_busy = 1'b1;
    end else if (tx_busy && tick) begin
      next_tx_tk = tx_tk + 4'h1;
      if (tx_tk == `SPL_TICK_LAST) begin
        next_tx_sh   = {1'b1, tx_sh[11:1]};
        next_tx_left = tx_left - 4'h1;
        if (tx_left == 4'h1) next_tx_busy = 1'b0;
      end
    end
    next_txd = next_tx_busy ? next_tx_sh[0] : 1'b1;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh   <= 12'hFFF;
      tx_left <= 4'h0;
      tx_tk   <= 4'h0;
      tx_busy <= 1'b0;
      txd_o   <= 1'b1;
    end else begin
      tx_sh   <= next_tx_sh;
      tx_left <= next_tx_left;
      tx_tk   <= next_tx_tk;
      tx_busy <= next_tx_busy;
      txd_o   <= next_txd;
    end
  end

  // Receiver: mid-bit sampling; finishes on the first stop bit so a second is optional.
  logic [8:0] rx_sh, next_rx_sh;
  logic [3:0] rx_idx, next_rx_idx, rx_tk, next_rx_tk, rx_last;
  logic       rx_busy, next_rx_busy, rx_done, rx_perr, rx_ferr, rx_flow, rx_deliver;
  logic [7:0] rx_char;
  assign rx_last = 4'h1 + (fr.eight ? 4'h8 : 4'h7) + {3'h0, fr.par_en};
  assign rx_done = rx_busy && tick && rx_tk == `SPL_TICK_MID && rx_idx == rx_last;

  always_comb begin
    next_rx_sh   = rx_sh;
    next_rx_idx  = rx_idx;
    next_rx_tk   = rx_tk;
    next_rx_busy = rx_busy;
    rx_char      = fr.eight ? rx_sh[7:0] : {1'b0, rx_sh[6:0]};
    rx_perr      = fr.par_en && ((fr.eight ? rx_sh[8] : rx_sh[7]) != (fr.par_odd ? ~^rx_char : ^rx_char));
    if (fr.rs244) begin
      rx_char = {1'b0, rx_sh[7:5], rx_sh[3:0]};
      rx_perr = ~^rx_sh[7:0];
    end
    rx_ferr = !rx_line;
    if (!rx_busy) begin
      if (!rx_line) begin
        next_rx_busy = 1'b1;
        next_rx_idx  = 4'h0;
        next_rx_tk   = 4'h0;
      end
    end else if (tick) begin
      next_rx_tk = rx_tk + 4'h1;
      if (rx_tk == `SPL_TICK_MID) begin
        if (rx_idx == 4'h0 && rx_line) next_rx_busy = 1'b0; // Glitch, not a start bit.
        else if (rx_idx == rx_last) next_rx_busy = 1'b0;
        else if (rx_idx != 4'h0) next_rx_sh[rx_idx - 4'h1] = rx_line; // LSB first.
      end
      if (rx_tk == `SPL_TICK_LAST) next_rx_idx = rx_idx + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh   <= 9'h000;
      rx_idx  <= 4'h0;
      rx_tk   <= 4'h0;
      rx_busy <= 1'b0;
    end else begin
      rx_sh   <= next_rx_sh;
      rx_idx  <= next_rx_idx;
      rx_tk   <= next_rx_tk;
      rx_busy <= next_rx_busy;
    end
  end

  // Flow characters are consumed only under the character protocol.
  assign rx_flow    = settings.flow_protocol_select == SPL_PROT_XONOFF
                   && (rx_char == `SPL_XON || rx_char == `SPL_XOFF);
  assign rx_deliver = rx_done && active && !mode_store && !rx_flow;

  // Transfer sequencer.
  always_comb begin
    next_state      = state;
    next_mode_store = mode_store;
    next_dly_cnt    = dly_cnt;
    case (state)
      SPL_IDLE: begin
        if (cmd_load || cmd_store) begin
          next_state      = SPL_SETUP;
          next_mode_store = cmd_store;
        end
      end
      SPL_SETUP:   if (settings_ok) next_state = SPL_WAIT;
      SPL_WAIT: begin
        next_dly_cnt = 32'h0000_0000;
        if (online) next_state = SPL_DELAY;
      end
      SPL_DELAY: begin
        next_dly_cnt = dly_cnt + 32'h0000_0001;
        if (!online) next_state = SPL_WAIT;
        else if (dly_cnt == ONLINE_DELAY_CYC - 1) next_state = SPL_XFER;
      end
      SPL_XFER: begin
        if (cmd_finish) next_state = SPL_DONE;
        else if (!online) next_state = SPL_PAUSED;
      end
      SPL_PAUSED:  if (online) next_state = SPL_XFER;
      SPL_DONE:    if (cmd_abort) next_state = SPL_IDLE;
      SPL_ABORTED: if (cmd_abort) next_state = SPL_IDLE;
      default:     next_state = SPL_IDLE;
    endcase
    if (cmd_abort && state != SPL_IDLE && state != SPL_DONE && state != SPL_ABORTED) begin
      next_state = SPL_ABORTED;
    end
    next_ctrl_out = next_state == SPL_WAIT || next_state == SPL_DELAY
                 || next_state == SPL_XFER || next_state == SPL_PAUSED;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state      <= SPL_IDLE;
      mode_store <= 1'b0;
      dly_cnt    <= 32'h0000_0000;
      ctrl_out_o <= 1'b0;
    end else begin
      state      <= next_state;
      mode_store <= next_mode_store;
      dly_cnt    <= next_dly_cnt;
      ctrl_out_o <= next_ctrl_out;
    end
  end

  // Registers, data paths and interrupt status; hardware sets win over clears.
  always_comb begin
    logic [`SPL_IRQ_W-1:0] set;
    set           = '0;
    next_settings = settings;
    next_irq_mask = irq_mask;
    next_tx_hold  = tx_hold;
    next_tx_full  = tx_full && !tx_start;
    next_rx_data  = rx_data;
    next_rx_valid = rx_valid && !(rd_take && avs_address_i == `SPL_REG_RXDATA);
    next_xoff     = xoff;
    next_count    = count;
    next_wait     = !((avs_read_i || avs_write_i) && avs_waitrequest_o);
    next_rdata    = 32'h0000_0000;
    if (wr && avs_address_i == `SPL_REG_SETTINGS) next_settings = spl_settings_t'(avs_writedata_i[15:0]);
    if (wr && avs_address_i == `SPL_REG_IRQ_MASK) next_irq_mask = avs_writedata_i[`SPL_IRQ_W-1:0];
    if (wr && avs_address_i == `SPL_REG_TXDATA) begin
      if (tx_full && !tx_start) set[`SPL_IRQ_OVR] = 1'b1; // Dropped: holding byte still waiting.
      else begin
        next_tx_hold = avs_writedata_i[7:0];
        next_tx_full = 1'b1;
      end
    end
    if (tx_start) set[`SPL_IRQ_TXE] = 1'b1;
    if (rx_done && active && rx_flow) next_xoff = (rx_char == `SPL_XOFF);
    if (state == SPL_IDLE) next_xoff = 1'b0;
    if (rx_done && active) begin
      set[`SPL_IRQ_PAR] = rx_perr;
      set[`SPL_IRQ_FRM] = rx_ferr;
    end
    if (rx_deliver) begin
      if (next_rx_valid) set[`SPL_IRQ_OVR] = 1'b1;
      next_rx_data      = rx_char;
      next_rx_valid     = 1'b1;
      set[`SPL_IRQ_RX]  = 1'b1;
    end
    if ((cmd_load || cmd_store) && state == SPL_IDLE) next_count = 32'h0000_0000;
    else if (rx_deliver || (tx_done && mode_store)) next_count = count + 32'h0000_0001;
    if (state == SPL_DELAY && next_state == SPL_XFER) set[`SPL_IRQ_ONLINE] = 1'b1;
    if (next_state == SPL_ABORTED && state != SPL_ABORTED) set[`SPL_IRQ_ABORT] = 1'b1;
    next_irq_stat = irq_stat;
    if (wr && avs_address_i == `SPL_REG_IRQ_STAT) next_irq_stat = irq_stat & ~avs_writedata_i[`SPL_IRQ_W-1:0];
    next_irq_stat = next_irq_stat | set;
    next_irq      = |(next_irq_stat & next_irq_mask);
    case (avs_address_i)
      `SPL_REG_SETTINGS: next_rdata = {16'h0000, settings};
      `SPL_REG_STATUS:   next_rdata = {25'h0, xoff, rx_valid, !tx_full, online, state};
      `SPL_REG_RXDATA:   next_rdata = {24'h0, rx_data};
      `SPL_REG_COUNT:    next_rdata = count;
      `SPL_REG_IRQ_STAT: next_rdata = {25'h0, irq_stat};
      `SPL_REG_IRQ_MASK: next_rdata = {25'h0, irq_mask};
      default:           next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      settings          <= '0;
      irq_mask          <= '0;
      irq_stat          <= '0;
      tx_hold           <= 8'h00;
      tx_full           <= 1'b0;
      rx_data           <= 8'h00;
      rx_valid          <= 1'b0;
      xoff              <= 1'b0;
      count             <= 32'h0000_0000;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
      irq_o             <= 1'b0;
    end else begin
      settings          <= next_settings;
      irq_mask          <= next_irq_mask;
      irq_stat          <= next_irq_stat;
      tx_hold           <= next_tx_hold;
      tx_full           <= next_tx_full;
      rx_data           <= next_rx_data;
      rx_valid          <= next_rx_valid;
      xoff              <= next_xoff;
      count             <= next_count;
      avs_waitrequest_o <= next_wait;
      if (avs_waitrequest_o) avs_readdata_o <= next_rdata;
      irq_o             <= next_irq;
    end
  end

  // Checks on the sequencer and the link.
  a_status_out_wait: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    state == SPL_WAIT |-> ctrl_out_o) else $error("status output low while waiting");
  a_delay_full_sec: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    state == SPL_XFER && $past(state) == SPL_DELAY |-> $past(dly_cnt) == ONLINE_DELAY_CYC - 1)
    else $error("transfer began before the online delay");
  a_pause_on_drop: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    state == SPL_XFER && !online && !cmd_abort && !cmd_finish |=> state == SPL_PAUSED)
    else $error("transfer not suspended on status drop");
  a_abort_enter: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    cmd_abort && state inside {SPL_SETUP, SPL_WAIT, SPL_DELAY, SPL_XFER, SPL_PAUSED}
    |=> state == SPL_ABORTED && irq_stat[`SPL_IRQ_ABORT]) else $error("abort not taken");
  a_abort_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    state == SPL_ABORTED && cmd_abort |=> state == SPL_IDLE) else $error("second abort not idle");
  a_setup_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    state == SPL_SETUP && !settings_ok && !cmd_abort |=> state == SPL_SETUP && !ctrl_out_o)
    else $error("left setup with unset settings");
  a_tx_start_bit: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $rose(tx_busy) |-> !txd_o ##1 !txd_o) else $error("no start bit");
  a_tx_two_stops: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    tx_busy && tx_left <= 4'h2 |-> txd_o) else $error("stop bit low");
  a_count_step: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    rx_deliver || (tx_done && mode_store) |=> count == $past(count) + 32'h0000_0001)
    else $error("byte count not advanced");
  a_parity_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    rx_done && active && rx_perr |=> irq_stat[`SPL_IRQ_PAR]) else $error("parity error lost");

endmodule // spl_uart
`default_nettype wire

// >>> dv/spl_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module spl_host_model #(
  parameter int BIT = 432
) (
  // Clock, status control and link pins.
  input  wire logic ref_clk_i,
  input  wire logic online_i,
  input  wire logic txd_i,
  output logic      rxd_o,
  output wire logic stat_o
);
  logic [11:0] sh;
  int          got_n = 0;
  initial rxd_o = 1'b1;
  // Status line follows the bench's online request.
  assign stat_o = online_i;
  // Sends even parity, eight bits, LSB first, two stops; bad corrupts parity and first stop.
  task automatic send(input logic [7:0] b, input logic bad);
    logic [11:0] f;
    f = {1'b1, ~bad, ^b ^ bad, b, 1'b0};
    for (int i = 0; i < 12; i++) begin
      rxd_o <= f[i];
      repeat (BIT) @(posedge ref_clk_i);
    end
  endtask
  // Captures each frame mid-bit, both stop bits included, so a short stop shows up.
  always begin
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge ref_clk_i);
    for (int i = 0; i < 12; i++) begin
      sh[i] = txd_i;
      repeat (BIT) @(posedge ref_clk_i);
    end
    got_n++;
  end
endmodule // spl_host_model
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "spl_params.svh"
module tb;
  localparam int BIT = 16 * (`SPL_CLK_HZ / (16 * `SPL_BAUD_D));
  logic        clk    = 1'b0;
  logic        rst_n  = 1'b0;
  logic [4:0]  adr    = 5'h00;
  logic        rd_en  = 1'b0;
  logic        wr_en  = 1'b0;
  logic [31:0] wdat   = 32'h0;
  logic        online = 1'b0;
  logic [31:0] rdat;
  logic [31:0] rv;
  logic        wreq, irq, txd, rxd, stat, ctrl;
  int          fails = 0;
  int          cmp_count = 0;
  // Free-running 100 MHz clock.
  always #5 clk = ~clk;
  spl_uart #(.ONLINE_DELAY_CYC(50)) DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr),
    .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .irq_o(irq), .rxd_i(rxd), .txd_o(txd), .stat_in_i(stat), .ctrl_out_o(ctrl));
  spl_host_model #(.BIT(BIT)) hst (.ref_clk_i(clk), .online_i(online), .txd_i(txd), .rxd_o(rxd), .stat_o(stat));
  // Bus cycles hold the request until waitrequest is seen low at an edge.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    adr <= a;
    wdat <= d;
    wr_en <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a);
    adr <= a;
    rd_en <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    rv = rdat;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stt(input logic [31:0] s);
    rd(5'h08);
    chk(rv & 32'h7, s);
  endtask
  task automatic end_of_test();
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // A hang counts as a mismatch; the run needs about 27000 cycles.
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    end_of_test();
  end
  // Store, pause, send, abort twice, then load with a clean frame, flow characters and a corrupt frame.
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    stt(32'h0);
    wr(5'h00, 32'h0);
    wr(5'h04, 32'h2);
    stt(32'h1);
    chk(ctrl, 32'h0);
    wr(5'h00, 32'h11D4);
    rd(5'h00);
    chk(rv, 32'h11D4);
    repeat (4) @(posedge clk);
    stt(32'h3);
    chk(ctrl, 32'h1);
    wr(5'h1C, 32'h10);
    online <= 1'b1;
    repeat (20) @(posedge clk);
    stt(32'h2);
    chk(irq, 32'h0);
    repeat (60) @(posedge clk);
    stt(32'h6);
    chk(irq, 32'h1);
    wr(5'h18, 32'h10);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0);
    online <= 1'b0;
    repeat (10) @(posedge clk);
    stt(32'h7);
    online <= 1'b1;
    repeat (10) @(posedge clk);
    stt(32'h6);
    wr(5'h0C, 32'hA5);
    repeat (13 * BIT) @(posedge clk);
    chk(hst.got_n, 32'h1);
    chk(hst.sh, 32'hD4A);
    rd(5'h14);
    chk(rv, 32'h1);
    wr(5'h04, 32'h4);
    stt(32'h4);
    wr(5'h04, 32'h4);
    stt(32'h0);
    wr(5'h04, 32'h1);
    repeat (80) @(posedge clk);
    stt(32'h6);
    hst.send(8'h3C, 1'b0);
    rd(5'h10);
    chk(rv & 32'hFF, 32'h3C);
    rd(5'h14);
    chk(rv, 32'h1);
    wr(5'h00, 32'h12D4);
    hst.send(`SPL_XOFF, 1'b0);
    wr(5'h0C, 32'h5A);
    rd(5'h08);
    chk(rv, 32'h4E);
    hst.send(`SPL_XON, 1'b0);
    rd(5'h08);
    chk(rv, 32'h1E);
    rd(5'h14);
    chk(rv, 32'h1);
    hst.send(8'h3C, 1'b1);
    rd(5'h18);
    chk(rv, 32'h3F);
    wr(5'h04, 32'h8);
    stt(32'h5);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
